// file: pkg/spc_pkg.sv
// constants and types for the serial and byte-wide configuration loader
package spc_pkg;
  // ****************************************
  // mode pin patterns, ordered hi, mid, lo
  // ****************************************
  localparam logic [2:0] SPC_MODE_SERIAL = 3'h7;
  localparam logic [2:0] SPC_MODE_ASYNC  = 3'h5;

  // ****************************************
  // timing: clock rate in MHz, period in ns, counts in config or system clocks
  // ****************************************
  localparam int SPC_CLK_MHZ           = 50;
  localparam int SPC_CONFIG_CLOCK_NS           = 160;   // internal config clock period
  localparam int SPC_CONFIG_CLOCK_DIV          = (SPC_CONFIG_CLOCK_NS * SPC_CLK_MHZ) / 1000;
  localparam int SPC_BUSY_MIN_CONFIG_CLOCK     = 2;
  localparam int SPC_BUSY_MAX_CONFIG_CLOCK     = 9;
  localparam int SPC_INIT_CLEAR_CYCLES = 16;    // init held low after reset
  localparam logic [7:0] SPC_BYTE_RESET = 8'h00;

  // loader states
  typedef enum logic [2:0] {
    SPC_ST_INIT  = 3'b001,
    SPC_ST_LOAD  = 3'b010,
    SPC_ST_IDLE  = 3'b100
  } spc_state_t;
endpackage : spc_pkg

// file: logic/spc_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module spc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // pins
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : spc_sync

// file: logic/spc_loader.sv
// serial slave and byte-wide asynchronous configuration loader
`timescale 1ns/1ps
module spc_loader
  import spc_pkg::*;
#(
  parameter int INIT_CYCLES = SPC_INIT_CLEAR_CYCLES,
  parameter int CONFIG_CLOCK_DIV    = SPC_CONFIG_CLOCK_DIV
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // mode pins (pulled up outside)
  input  wire logic       i_mode_sel_hi,
  input  wire logic       i_mode_sel_mid,
  input  wire logic       i_mode_sel_lo,
  // serial link
  input  wire logic       i_config_clock,
  input  wire logic       i_serial_din,
  output logic            o_serial_dout,
  // init open-drain pin
  input  wire logic       i_init,
  output logic            o_init,
  output logic            o_init_oe,
  // byte-wide host port
  input  wire logic       i_chip_select_low_active_n,
  input  wire logic       i_chip_select_high_active,
  input  wire logic       i_write_strobe_n,
  input  wire logic       i_read_strobe_n,
  input  wire logic [7:0] i_data,
  output logic            o_ready_busy,
  // config stream toward the fabric
  output logic            o_cfg_bit,
  output logic            o_cfg_valid,
  output logic            o_init_seen_high,
  // frame length the core itself needs
  input  wire logic [31:0] i_own_bits
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [14:0] pins_s;
  spc_sync #(.W(15)) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async ({i_mode_sel_hi, i_mode_sel_mid, i_mode_sel_lo, i_config_clock,
               i_serial_din, i_init, i_chip_select_low_active_n,
               i_chip_select_high_active, i_write_strobe_n, i_read_strobe_n,
               i_data[4:0]}),
    .o_sync  (pins_s)
  );
  // data bits 7:5 get their own two stages, same delay as the strobe decode
  logic [2:0] data_hi_s;
  spc_sync #(.W(3)) u_sync_d (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_data[7:5]),
    .o_sync  (data_hi_s)
  );

  logic [2:0] mode_s;
  logic       config_clock_s;
  logic       din_s;
  logic       init_s;
  logic       write_act;
  logic [7:0] data_s;
  assign mode_s    = pins_s[14:12];
  assign config_clock_s    = pins_s[11];
  assign din_s     = pins_s[10];
  assign init_s    = pins_s[9];
  assign data_s    = {data_hi_s, pins_s[4:0]};
  assign write_act = !pins_s[8] && pins_s[7] && !pins_s[6] && pins_s[5];

  // ****************************************
  // mode latch and init sequencing
  // ****************************************
  spc_state_t state_q;
  logic [2:0] mode_q;
  logic [15:0] init_cnt_q;
  logic        is_serial;
  logic        is_async;
  // serial slave on 111; pull-ups make floating pins read 111
  assign is_serial = (mode_q == SPC_MODE_SERIAL);
  assign is_async  = (mode_q == SPC_MODE_ASYNC);

  // mode caught once after reset, after sync settles
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q    <= SPC_ST_INIT;
      mode_q     <= SPC_MODE_SERIAL;
      init_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        SPC_ST_INIT: begin
          init_cnt_q <= init_cnt_q + 16'h0001;
          if (init_cnt_q == 16'(INIT_CYCLES)) begin
            mode_q  <= mode_s;
            state_q <= SPC_ST_LOAD;
          end
        end
        SPC_ST_LOAD: state_q <= SPC_ST_LOAD;
        default:     state_q <= SPC_ST_INIT;
      endcase
    end
  end

  // open drain: only ever drive low, release to the pull-up
  assign o_init    = 1'b0;
  assign o_init_oe = (state_q == SPC_ST_INIT);
  // the shared wire high tells every chained device is ready
  assign o_init_seen_high = init_s && (state_q == SPC_ST_LOAD);

  // ****************************************
  // serial slave path
  // ****************************************
  logic config_clock_d1_q;
  logic config_clock_rise;
  logic config_clock_fall;
  logic [31:0] bit_cnt_q;
  logic fwd_q;
  logic fwd_pend_q;
  logic ser_bit_q;
  logic ser_valid_q;
  always_ff @(posedge i_clk) begin
    if (i_reset) config_clock_d1_q <= 1'b0;
    else         config_clock_d1_q <= config_clock_s;
  end
  // config clock comes from the source; edges found here
  assign config_clock_rise = config_clock_s && !config_clock_d1_q;
  assign config_clock_fall = !config_clock_s && config_clock_d1_q;

  // sample data on rising config clock edge
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bit_cnt_q   <= 32'h0000_0000;
      ser_bit_q   <= 1'b0;
      ser_valid_q <= 1'b0;
      fwd_pend_q  <= 1'b0;
      fwd_q       <= 1'b1;
    end else begin
      ser_valid_q <= 1'b0;
      if (is_serial && state_q == SPC_ST_LOAD && config_clock_rise) begin
        // own bits stay here; surplus bits go downstream
        if (bit_cnt_q < i_own_bits) begin
          bit_cnt_q   <= bit_cnt_q + 32'h0000_0001;
          ser_bit_q   <= din_s;
          ser_valid_q <= 1'b1;
          fwd_pend_q  <= 1'b1;   // downstream sees ones while own bits load
        end else begin
          fwd_pend_q  <= din_s;
        end
      end
      // output moves half a period later on falling edge
      if (config_clock_fall) begin
        fwd_q <= fwd_pend_q;
      end
    end
  end
  assign o_serial_dout = fwd_q;

  // ****************************************
  // byte-wide path: holding and shift stage
  // ****************************************
  logic       write_d1_q;
  logic       write_end;
  logic [7:0] data_held_q;
  logic [7:0] hold_q;
  logic       hold_full_q;
  logic [7:0] shift_q;
  logic [3:0] shift_cnt_q;
  logic [7:0] div_q;
  logic       tick;
  logic       par_bit_q;
  logic       par_valid_q;
  logic [3:0] busy_cnt_q;

  // free-running internal config clock; phase sets start delay
  always_ff @(posedge i_clk) begin
    if (i_reset || div_q == 8'(CONFIG_CLOCK_DIV - 1)) div_q <= 8'h00;
    else                                       div_q <= div_q + 8'h01;
  end
  assign tick = (div_q == 8'(CONFIG_CLOCK_DIV - 1));

  always_ff @(posedge i_clk) begin
    if (i_reset) write_d1_q <= 1'b0;
    else         write_d1_q <= write_act;
  end
  // byte taken at strobe release, from the copy latched while the strobe was low
  assign write_end = write_d1_q && !write_act;

  // last byte seen while the strobe was low; host may drop data with it
  always_ff @(posedge i_clk) begin
    if (i_reset)        data_held_q <= SPC_BYTE_RESET;
    else if (write_act) data_held_q <= data_s;
  end

  // two-stage converter; hold waits while shifter busy
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      hold_q      <= SPC_BYTE_RESET;
      hold_full_q <= 1'b0;
      shift_q     <= SPC_BYTE_RESET;
      shift_cnt_q <= 4'h0;
      par_bit_q   <= 1'b0;
      par_valid_q <= 1'b0;
    end else begin
      par_valid_q <= 1'b0;
      if (write_end && is_async && state_q == SPC_ST_LOAD) begin
        hold_q      <= data_held_q;
        hold_full_q <= 1'b1;
      end
      if (tick) begin
        if (shift_cnt_q != 4'h0) begin
          par_bit_q   <= shift_q[7];
          par_valid_q <= 1'b1;
          shift_q     <= {shift_q[6:0], 1'b0};
          shift_cnt_q <= shift_cnt_q - 4'h1;
        end else if (hold_full_q && !write_end) begin
          shift_q     <= hold_q;
          shift_cnt_q <= 4'h8;
          hold_full_q <= 1'b0;
        end
      end
    end
  end

  // busy from accept until hold frees, at least two periods
  always_ff @(posedge i_clk) begin
    if (i_reset) busy_cnt_q <= 4'h0;
    else if (write_end && is_async && state_q == SPC_ST_LOAD)
      // one extra tick: the first may follow at once, still two full periods
      busy_cnt_q <= 4'(SPC_BUSY_MIN_CONFIG_CLOCK + 1);
    else if (tick && busy_cnt_q != 4'h0) busy_cnt_q <= busy_cnt_q - 4'h1;
  end
  // host sees busy low while converter full
  assign o_ready_busy = !(hold_full_q || busy_cnt_q != 4'h0);

  // ****************************************
  // merged stream toward the core
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_cfg_bit   <= 1'b0;
      o_cfg_valid <= 1'b0;
    end else begin
      o_cfg_valid <= ser_valid_q || par_valid_q;
      o_cfg_bit   <= is_serial ? ser_bit_q : par_bit_q;
    end
  end
endmodule : spc_loader

// file: tb/spc_loader_chk.sv
// port checker for the configuration loader
`timescale 1ns/1ps
module spc_loader_chk #(
  parameter int CONFIG_CLOCK_DIV = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_config_clock,
  input wire logic i_init,
  input wire logic o_init,
  input wire logic o_init_oe,
  input wire logic o_serial_dout,
  input wire logic o_ready_busy,
  input wire logic o_cfg_valid,
  input wire logic o_init_seen_high
);
  // ****
  // port relations
  // ****
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [7:0] low_q;
  // busy run length, cleared while ready
  always_ff @(posedge i_clk) begin
    low_q <= (i_reset || o_ready_busy) ? 8'h00 : low_q + 8'h01;
  end
  property p_rst;
    disable iff (1'b0) i_reset |=> o_serial_dout && o_ready_busy && o_init_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_od; !o_init; endproperty
  a_od: assert property (p_od) else $error("init high");
  property p_seen; o_init_seen_high |-> i_init && !o_init_oe; endproperty
  a_seen: assert property (p_seen) else $error("init seen");
  property p_vld; o_cfg_valid |=> !o_cfg_valid; endproperty
  a_vld: assert property (p_vld) else $error("valid long");
  property p_bmin; $rose(o_ready_busy) |-> low_q >= 2 * CONFIG_CLOCK_DIV; endproperty
  a_bmin: assert property (p_bmin) else $error("busy short");
  property p_bmax; !o_ready_busy |-> low_q < 9 * CONFIG_CLOCK_DIV; endproperty
  a_bmax: assert property (p_bmax) else $error("busy long");
  property p_bhold; $fell(o_ready_busy) |=> !o_ready_busy [*8]; endproperty
  a_bhold: assert property (p_bhold) else $error("busy gap");
  property p_dfall; $changed(o_serial_dout) |-> !$past(i_config_clock, 2); endproperty
  a_dfall: assert property (p_dfall) else $error("dout edge");
  c_busy: cover property ($rose(o_ready_busy));
  c_vld: cover property (o_cfg_valid);
  c_rel: cover property ($fell(o_init_oe));
endmodule : spc_loader_chk

bind spc_loader spc_loader_chk #(.CONFIG_CLOCK_DIV(CONFIG_CLOCK_DIV)) u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_config_clock(i_config_clock), .i_init(i_init),
  .o_init(o_init), .o_init_oe(o_init_oe), .o_serial_dout(o_serial_dout),
  .o_ready_busy(o_ready_busy), .o_cfg_valid(o_cfg_valid), .o_init_seen_high(o_init_seen_high)
);

// file: tb/spc_src_model.sv
// serial configuration source driving link clock and data
`timescale 1ns/1ps
module spc_src_model (
  // shared init wire
  input  wire logic i_init,
  // serial link
  output logic      o_cc,
  output logic      o_din
);
  // ****
  // frame sender
  // ****
  // link clock stands low between frames
  initial begin
    o_cc = 1'b0;
    o_din = 1'b1;
  end
  // we own the clock, data ahead of rise
  task automatic send(input logic [15:0] v, input int n);
    int i;
    for (i = 0; i < 400 && i_init !== 1'b1; i++) #20;
    // non-blocking: edges land on system clock edges without a race
    for (i = n - 1; i >= 0; i--) begin
      o_cc <= 1'b0;
      o_din <= v[i];
      #80;
      o_cc <= 1'b1;
      #80;
    end
    o_cc <= 1'b0;
    #80;
    o_din <= ~o_din;  // released line shows no stale bit
  endtask : send
endmodule : spc_src_model

// file: tb/spc_loader_tb.sv
// self-checking bench for the configuration loader
`timescale 1ns/1ps
module spc_loader_tb;
  logic        clk, rst, cs_n, cs1, ws_n, rs_n;
  logic [2:0]  mode;
  logic [7:0]  dat;
  logic [15:0] v;
  logic        qc[$], qd[$];
  int          seed, bad_count, check_count, i;
  wire logic   cc, din, dout, oe, o_init, rdy, cbit, cval, init_w, seen;
  // ****
  // wiring
  // ****
  // pull-up on the shared init wire
  assign init_w = oe ? o_init : 1'b1;
  always #10 clk = ~clk;
  spc_src_model u_src (.i_init(init_w), .o_cc(cc), .o_din(din));
  spc_loader #(.INIT_CYCLES(4)) dut (
    .i_clk(clk), .i_reset(rst), .i_mode_sel_hi(mode[2]), .i_mode_sel_mid(mode[1]),
    .i_mode_sel_lo(mode[0]), .i_config_clock(cc), .i_serial_din(din),
    .o_serial_dout(dout), .i_init(init_w), .o_init(o_init), .o_init_oe(oe),
    .i_chip_select_low_active_n(cs_n), .i_chip_select_high_active(cs1),
    .i_write_strobe_n(ws_n), .i_read_strobe_n(rs_n), .i_data(dat), .o_ready_busy(rdy),
    .o_cfg_bit(cbit), .o_cfg_valid(cval), .o_init_seen_high(seen), .i_own_bits(32'h0000_0004)
  );
  task automatic cmp(input string n, input logic e, input logic s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, s);
    end
  endtask : cmp
  task automatic final_report();
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // reset with a mode pattern, then wait for init release
  task automatic restart(input logic [2:0] m);
    int k;
    @(posedge clk);
    rst <= 1'b1;
    mode <= m;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 100 && oe !== 1'b0; k++) @(posedge clk);
    cmp("init_release", 1'b0, oe);
    for (k = 0; k < 5 && seen !== 1'b1; k++) @(posedge clk);
    cmp("init_seen", 1'b1, seen);
    cmp("init_drive", 1'b0, o_init);
  endtask : restart
  // byte write held until ready stood nine clocks
  task automatic wr(input logic [7:0] b);
    int k, hi;
    cs_n <= 1'b0;
    cs1 <= 1'b1;
    ws_n <= 1'b0;
    dat <= b;
    for (k = 7; k >= 0; k--) qc.push_back(b[k]);
    hi = 0;
    for (k = 0; k < 300 && hi < 9; k++) begin
      @(posedge clk);
      hi = (rdy === 1'b1) ? hi + 1 : 0;
    end
    cmp("ready_wait", 1'b1, hi >= 9);
    cs_n <= 1'b1;
    cs1 <= 1'b0;
    ws_n <= 1'b1;
    dat <= ~b;  // data dropped right at strobe end
    for (k = 0; k < 6 && rdy !== 1'b0; k++) @(posedge clk);
    cmp("busy_after_write", 1'b0, rdy);
  endtask : wr
  // loaded bits, oldest note first
  always @(posedge clk) begin
    if (cval === 1'b1) begin
      if (qc.size() == 0) cmp("cfg_extra", 1'b0, 1'b1);
      else cmp("cfg_bit", qc.pop_front(), cbit);
    end
  end
  // forwarded bit settles after each falling link edge
  always @(negedge cc) begin
    repeat (4) @(posedge clk);
    if (qd.size() > 0) cmp("dout", qd.pop_front(), dout);
  end
  initial begin
    seed = 73;
    clk = 1'b0;
    rst = 1'b1;
    mode = 3'h7;
    cs_n = 1'b1;
    cs1 = 1'b0;
    ws_n = 1'b1;
    rs_n = 1'b1;
    dat = 8'h00;
    restart(3'h7);
    v = 16'($random(seed));
    // four own bits kept, the rest forwarded
    for (i = 11; i >= 0; i--) begin
      qd.push_back(i > 7 ? 1'b1 : v[i]);
      if (i > 7) qc.push_back(v[i]);
    end
    u_src.send(v, 12);
    restart(3'h5);
    for (i = 0; i < 3; i++) begin
      v = 16'($random(seed));
      wr(v[7:0]);
    end
    for (i = 0; i < 400 && qc.size() > 0; i++) @(posedge clk);
    cmp("all_bits_out", 1'b1, qc.size() == 0);
    final_report();
  end
endmodule : spc_loader_tb
